//--- design/uart_modem_lines_consts.vh
// Constants for the modem-line and transmit-space block
`ifndef UART_MODEM_LINES_CONSTS_VH
`define UART_MODEM_LINES_CONSTS_VH

// ----------------------------------------------------------------
// Register bus layout
// ----------------------------------------------------------------
`define ADDR_W          5
`define DATA_W          8
`define CHAN_MSB        4
`define CHAN_LSB        3
`define IDX_MSB         2
`define IDX_LSB         0

// ----------------------------------------------------------------
// Register indices within one channel
// ----------------------------------------------------------------
`define IDX_MODEM_CTRL  3'h0
`define IDX_ENH_FEAT    3'h1
`define IDX_MODEM_STAT  3'h2
`define IDX_TX_STAT     3'h3
`define IDX_INT_MASK    3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCR_TERM_READY  0
`define MCR_REQ_SEND    1
`define EFR_AUTO_RTS    6
`define EFR_AUTO_CTS    7
`define MSR_CTS         4
`define TXS_SPACE       0
`define TXS_EMPTY       1
`define TXS_FULL        2

// ----------------------------------------------------------------
// Reset values and defaults
// ----------------------------------------------------------------
`define MCR_RESET       8'h00
`define EFR_RESET       8'h00
`define MASK_RESET      4'h0
`define PIN_IDLE        4'hf
`define RDATA_IDLE      8'h00
`define TX_DEPTH_DEF    64
`define LEVEL_W_DEF     7
`define NUM_CHAN_DEF    4

`endif

//--- design/uart_modem_lines_tx_ready.v
// Modem handshake lines and transmit-space signalling for a four-channel UART
`timescale 1ns/10ps
`default_nettype none
`include "uart_modem_lines_consts.vh"

module uart_modem_lines_tx_ready #(
  parameter NUM_CHAN = `NUM_CHAN_DEF,
  parameter TX_DEPTH = `TX_DEPTH_DEF,
  parameter LEVEL_W  = `LEVEL_W_DEF
) (
  input  wire                        core_clk,
  input  wire                        sys_rst,
  // Register port
  input  wire [`ADDR_W-1:0]          reg_addr,
  input  wire [`DATA_W-1:0]          reg_wdata,
  input  wire                        reg_wr,
  input  wire                        reg_rd,
  output reg  [`DATA_W-1:0]          reg_rdata,
  // Transmit fill state from the UART core
  input  wire [NUM_CHAN*LEVEL_W-1:0] tx_level,
  input  wire [NUM_CHAN-1:0]         tx_fifo_enable,
  // Receiver asks the far end to pause
  input  wire [NUM_CHAN-1:0]         rx_halt,
  // Modem inputs, active low
  input  wire [NUM_CHAN-1:0]         cts_n,
  input  wire [NUM_CHAN-1:0]         dsr_n,
  input  wire [NUM_CHAN-1:0]         ring_indicate_n,
  input  wire [NUM_CHAN-1:0]         carrier_detect_n,
  // Modem outputs, active low
  output reg  [NUM_CHAN-1:0]         dtr_n,
  output reg  [NUM_CHAN-1:0]         rts_n,
  // Transmit space outputs, active low
  output reg  [NUM_CHAN-1:0]         chan_tx_space_ready_n,
  output reg                         all_tx_space_ready_n,
  // Transmitter may send
  output reg  [NUM_CHAN-1:0]         tx_enable,
  output reg                         irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function sel_hit;
    input [`ADDR_W-1:0] addr;
    input integer       chan;
    input [2:0]         idx;
    reg   [1:0]         chan_bits;
    begin
      chan_bits = chan[1:0];
      sel_hit = (addr[`CHAN_MSB:`CHAN_LSB] == chan_bits) &&
                (addr[`IDX_MSB:`IDX_LSB] == idx);
    end
  endfunction

  // ----------------------------------------------------------------
  // Transmit capacity
  // ----------------------------------------------------------------
  // TX_DEPTH must fit in LEVEL_W bits, or full is flagged at the truncated, lower depth
  localparam [LEVEL_W-1:0] DEPTH_FULL = TX_DEPTH[LEVEL_W-1:0];
  localparam [LEVEL_W-1:0] DEPTH_THR  = {{(LEVEL_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Per-channel views
  // ----------------------------------------------------------------
  // Flattened per-channel state for the read mux
  wire [8*NUM_CHAN-1:0] mcr_flat;
  wire [8*NUM_CHAN-1:0] efr_flat;
  wire [8*NUM_CHAN-1:0] msr_flat;
  wire [8*NUM_CHAN-1:0] txs_flat;
  wire [4*NUM_CHAN-1:0] mask_flat;
  wire [NUM_CHAN-1:0]   space_vec;
  wire [NUM_CHAN-1:0]   int_vec;
  wire [NUM_CHAN-1:0]   next_dtr_n;
  wire [NUM_CHAN-1:0]   next_rts_n;
  wire [NUM_CHAN-1:0]   next_tx_enable;

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g = g + 1) begin : chan
      reg  [7:0]         modem_control_reg;
      reg  [7:0]         enhanced_feature_reg;
      reg  [3:0]         mask;
      reg  [3:0]         delta;
      reg  [3:0]         meta;
      reg  [3:0]         sync;
      reg  [3:0]         prev;
      wire [3:0]         pins_n;
      wire [3:0]         events;
      wire [LEVEL_W-1:0] level;
      wire [LEVEL_W-1:0] cap;
      wire               msr_read;
      wire               wr_mcr;
      wire               wr_efr;
      wire               wr_mask;
      wire               auto_pause;
      wire               cts_gate;
      wire               tx_empty;

      // --------------------------------------------------------------
      // Input synchroniser
      // --------------------------------------------------------------
      // Order: carrier, ring, data-set, clear-to-send
      assign pins_n = {carrier_detect_n[g], ring_indicate_n[g], dsr_n[g], cts_n[g]};

      // Two flops; only the second is looked at
      always @(posedge core_clk) begin
        if (sys_rst) begin
          meta <= `PIN_IDLE;
          sync <= `PIN_IDLE;
          prev <= `PIN_IDLE;
        end else begin
          meta <= pins_n;
          sync <= meta;
          prev <= sync;
        end
      end

      // --------------------------------------------------------------
      // Change detection
      // --------------------------------------------------------------
      // Ring event only on the trailing edge of ringing (pin back to 1)
      assign events = {sync[3] ^ prev[3],
                       ~prev[2] & sync[2],
                       sync[1] ^ prev[1],
                       sync[0] ^ prev[0]};

      assign msr_read = reg_rd && sel_hit(reg_addr, g, `IDX_MODEM_STAT);

      // Sticky change bits, cleared by a read; a new event wins
      always @(posedge core_clk) begin
        if (sys_rst) begin
          delta <= 4'h0;
        end else begin
          delta <= events | (msr_read ? 4'h0 : delta);
        end
      end

      // --------------------------------------------------------------
      // Software registers
      // --------------------------------------------------------------
      assign wr_mcr  = reg_wr && sel_hit(reg_addr, g, `IDX_MODEM_CTRL);
      assign wr_efr  = reg_wr && sel_hit(reg_addr, g, `IDX_ENH_FEAT);
      assign wr_mask = reg_wr && sel_hit(reg_addr, g, `IDX_INT_MASK);

      always @(posedge core_clk) begin
        if (sys_rst) begin
          modem_control_reg  <= `MCR_RESET;
          enhanced_feature_reg  <= `EFR_RESET;
          mask <= `MASK_RESET;
        end else begin
          if (wr_mcr) begin
            modem_control_reg <= reg_wdata;
          end
          if (wr_efr) begin
            enhanced_feature_reg <= reg_wdata;
          end
          if (wr_mask) begin
            mask <= reg_wdata[3:0];
          end
        end
      end

      // --------------------------------------------------------------
      // Transmit space
      // --------------------------------------------------------------
      // With the FIFO off only the holding register counts
      assign level = tx_level[g*LEVEL_W +: LEVEL_W];
      assign cap   = tx_fifo_enable[g] ? DEPTH_FULL : DEPTH_THR;
      assign space_vec[g] = (level < cap);

      // --------------------------------------------------------------
      // Modem outputs and flow control
      // --------------------------------------------------------------
      assign next_dtr_n[g] = ~modem_control_reg[`MCR_TERM_READY];
      // Auto mode drops the request while the receiver wants a pause
      assign auto_pause    = enhanced_feature_reg[`EFR_AUTO_RTS] & rx_halt[g];
      assign next_rts_n[g] = ~(modem_control_reg[`MCR_REQ_SEND] & ~auto_pause);
      // Data-set-ready is deliberately absent from this term
      assign cts_gate          = ~enhanced_feature_reg[`EFR_AUTO_CTS] | ~sync[0];
      assign next_tx_enable[g] = cts_gate;

      // --------------------------------------------------------------
      // Interrupt and register views
      // --------------------------------------------------------------
      assign int_vec[g] = |(delta & mask);

      assign mcr_flat[8*g +: 8]  = modem_control_reg;
      assign efr_flat[8*g +: 8]  = enhanced_feature_reg;
      assign msr_flat[8*g +: 8]  = {~sync, delta};
      assign mask_flat[4*g +: 4] = mask;
      assign tx_empty            = (level == {LEVEL_W{1'b0}});
      assign txs_flat[8*g +: 8]  = {5'h00,
                                    ~space_vec[g],
                                    tx_empty,
                                    space_vec[g]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux; unmapped indices read as zero
  // ----------------------------------------------------------------
  reg [`DATA_W-1:0] rd_mux;
  integer           k;

  always @* begin
    rd_mux = `RDATA_IDLE;
    for (k = 0; k < NUM_CHAN; k = k + 1) begin
      if (reg_addr[`CHAN_MSB:`CHAN_LSB] == k[1:0]) begin
        case (reg_addr[`IDX_MSB:`IDX_LSB])
          `IDX_MODEM_CTRL: begin
            rd_mux = mcr_flat[8*k +: 8];
          end
          `IDX_ENH_FEAT: begin
            rd_mux = efr_flat[8*k +: 8];
          end
          `IDX_MODEM_STAT: begin
            rd_mux = msr_flat[8*k +: 8];
          end
          `IDX_TX_STAT: begin
            rd_mux = txs_flat[8*k +: 8];
          end
          `IDX_INT_MASK: begin
            rd_mux = {4'h0, mask_flat[4*k +: 4]};
          end
          default: begin
            rd_mux = `RDATA_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the read strobe
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= `RDATA_IDLE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `RDATA_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Modem output flops
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      dtr_n <= {NUM_CHAN{1'b1}};
      rts_n <= {NUM_CHAN{1'b1}};
    end else begin
      dtr_n <= next_dtr_n;
      rts_n <= next_rts_n;
    end
  end

  // ----------------------------------------------------------------
  // Transmit space flops
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      chan_tx_space_ready_n <= {NUM_CHAN{1'b1}};
      all_tx_space_ready_n  <= 1'b1;
    end else begin
      chan_tx_space_ready_n <= ~space_vec;
      all_tx_space_ready_n  <= ~(|space_vec);
    end
  end

  // ----------------------------------------------------------------
  // Flow gate and interrupt flops
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      tx_enable <= {NUM_CHAN{1'b0}};
      irq       <= 1'b0;
    end else begin
      tx_enable <= next_tx_enable;
      irq       <= |int_vec;
    end
  end

endmodule
`default_nettype wire

//--- verif/modem_model.sv
// Behavioural modem driving the handshake inputs of the block
`timescale 1ns/10ps
`default_nettype none
module modem_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] ready,
  input  wire logic [3:0] powered,
  input  wire logic [3:0] ringing,
  input  wire logic [3:0] carrier,
  output var  logic [3:0] cts_n,
  output var  logic [3:0] dsr_n,
  output var  logic [3:0] ring_indicate_n,
  output var  logic [3:0] carrier_detect_n
);
  initial {cts_n, dsr_n, ring_indicate_n, carrier_detect_n} = 16'hffff;
  // Lines move just after an edge, never on it
  always @(posedge core_clk) begin
    cts_n            <= ~ready;
    dsr_n            <= ~powered;
    ring_indicate_n  <= ~ringing;
    carrier_detect_n <= ~carrier;
  end
endmodule
`default_nettype wire

//--- verif/uart_modem_lines_tx_ready_monitor.sv
// Port checker for the modem-line and transmit-space block
`timescale 1ns/10ps
`default_nettype none
module uart_modem_lines_tx_ready_monitor #(
  parameter NUM_CHAN = 4,
  parameter TX_DEPTH = 64,
  parameter LEVEL_W  = 7
) (
  input wire logic                        core_clk,
  input wire logic                        sys_rst,
  input wire logic [4:0]                  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_rdata,
  input wire logic [NUM_CHAN*LEVEL_W-1:0] tx_level,
  input wire logic [NUM_CHAN-1:0]         tx_fifo_enable,
  input wire logic [NUM_CHAN-1:0]         rx_halt,
  input wire logic [NUM_CHAN-1:0]         cts_n,
  input wire logic [NUM_CHAN-1:0]         ring_indicate_n,
  input wire logic [NUM_CHAN-1:0]         dtr_n,
  input wire logic [NUM_CHAN-1:0]         rts_n,
  input wire logic [NUM_CHAN-1:0]         chan_tx_space_ready_n,
  input wire logic                        all_tx_space_ready_n,
  input wire logic [NUM_CHAN-1:0]         tx_enable
);
  // Synchroniser needs a few edges after reset before pin relations hold
  reg [2:0] up;
  always @(posedge core_clk) begin
    if (sys_rst) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  genvar g;
  for (g = 0; g < NUM_CHAN; g = g + 1) begin : ch
    property p_space; !$past(sys_rst) |-> chan_tx_space_ready_n[g] ==
      ($past(tx_level[g*LEVEL_W +: LEVEL_W]) >= ($past(tx_fifo_enable[g]) ? TX_DEPTH : 1));
    endproperty
    a_space: assert property (p_space) else $error("space flag wrong");
  end
  property p_all; all_tx_space_ready_n == &chan_tx_space_ready_n; endproperty
  a_all: assert property (p_all) else $error("combined space flag wrong");
  property p_dtr; reg_wr && reg_addr == 5'h00 |-> ##2 dtr_n[0] == !$past(reg_wdata[0], 2);
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready wrong");
  property p_rts; reg_wr && reg_addr == 5'h00 |->
    ##2 ($past(rx_halt[0]) || rts_n[0] == !$past(reg_wdata[1], 2)); endproperty
  a_rts: assert property (p_rts) else $error("request to send wrong");
  property p_dtr_rst; $past(sys_rst) |-> &dtr_n; endproperty
  a_dtr_rst: assert property (p_dtr_rst) else $error("terminal ready after reset");
  property p_rts_rst; $past(sys_rst) |-> &rts_n; endproperty
  a_rts_rst: assert property (p_rts_rst) else $error("request to send after reset");
  property p_cts_stat; up == 3'h7 && reg_rd && reg_addr == 5'h02 && cts_n[0] == $past(cts_n[0])
    && cts_n[0] == $past(cts_n[0], 2) && cts_n[0] == $past(cts_n[0], 3)
    |=> reg_rdata[4] == !$past(cts_n[0]); endproperty
  a_cts_stat: assert property (p_cts_stat) else $error("status clear to send wrong");
  property p_cts_tx; up == 3'h7 && !cts_n[0] && !$past(cts_n[0]) && !$past(cts_n[0], 2)
    && !$past(cts_n[0], 3) |-> tx_enable[0]; endproperty
  a_cts_tx: assert property (p_cts_tx) else $error("transmit held with clear to send");
  sequence s_ring;
    up == 3'h7 && $rose(ring_indicate_n[0]) ##1 (!reg_rd)[*4] ##1 (reg_rd && reg_addr == 5'h02);
  endsequence
  property p_ring; s_ring |=> reg_rdata[2]; endproperty
  a_ring: assert property (p_ring) else $error("ring event not reported");
  property p_rdata; !reg_rd || reg_addr[2:0] > 3'h4 |=> reg_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data not idle");
  c_mcr: cover property (reg_wr && reg_addr == 5'h00);
  c_full: cover property (all_tx_space_ready_n);
  c_ring: cover property (s_ring);
endmodule
bind uart_modem_lines_tx_ready uart_modem_lines_tx_ready_monitor #(.NUM_CHAN(NUM_CHAN),
  .TX_DEPTH(TX_DEPTH), .LEVEL_W(LEVEL_W)) mon (.*);
`default_nettype wire

//--- verif/uart_modem_lines_tx_ready_tb.sv
// Self-checking bench for the modem-line and transmit-space block
`timescale 1ns/10ps
`default_nettype none
module uart_modem_lines_tx_ready_tb;
  logic        core_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00, d;
  logic [27:0] tx_level = 28'h0;
  logic [3:0]  tx_fifo_enable = 4'hf, rx_halt = 4'h0, ready = 4'h0, powered = 4'h0;
  logic [3:0]  ringing = 4'h0, carrier = 4'h0;
  wire logic [7:0] reg_rdata;
  wire logic [3:0] cts_n, dsr_n, ring_indicate_n, carrier_detect_n, dtr_n, rts_n, tx_enable;
  wire logic [3:0] chan_tx_space_ready_n;
  wire logic       all_tx_space_ready_n, irq;
  int n_fail = 0, checked = 0;
  always #2 core_clk = ~core_clk;
  uart_modem_lines_tx_ready uart_modem_lines_tx_ready_inst (.*);
  modem_model modem_model_inst (.*);
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task t_space;
    // Each channel at the edge of its capacity, fifo on ch0 and ch2 only
    tx_fifo_enable <= 4'h5;
    tx_level <= {7'h01, 7'h3f, 7'h00, 7'h40};
    cyc(2);
    chk("chan space", 8'h09, {4'h0, chan_tx_space_ready_n});
    chk("all space", 8'h00, {7'h0, all_tx_space_ready_n});
    rd(5'h03);
    chk("tx status 0", 8'h04, {5'h0, d[2:0]});
    rd(5'h0b);
    chk("tx status 1", 8'h03, {5'h0, d[2:0]});
    tx_level <= {7'h01, 7'h40, 7'h01, 7'h40};
    cyc(2);
    chk("all full", 8'h01, {7'h0, all_tx_space_ready_n});
    rd(5'h07);
    chk("unmapped", 8'h00, d);
  endtask
  task t_mcr;
    for (int v = 0; v < 4; v++) begin
      wr(5'h00, 8'(v));
      cyc(2);
      chk("dtr rts", {6'h0, ~v[0], ~v[1]}, {6'h0, dtr_n[0], rts_n[0]});
    end
    rd(5'h00);
    chk("control readback", 8'h03, d);
    rx_halt <= 4'h1;
    wr(5'h01, 8'h40);
    cyc(2);
    chk("auto rts", 8'h01, {7'h0, rts_n[0]});
    rd(5'h01);
    chk("feature readback", 8'h40, d);
    wr(5'h01, 8'h00);
    cyc(2);
    chk("rts status only", 8'h00, {7'h0, rts_n[0]});
    rx_halt <= 4'h0;
  endtask
  task t_cts;
    carrier <= 4'hf;
    cyc(5);
    chk("tx free", 8'h01, {7'h0, tx_enable[0]});
    rd(5'h02);
    chk("cts status", 8'h00, {7'h0, d[4]});
    wr(5'h01, 8'h80);
    cyc(3);
    chk("tx held", 8'h00, {7'h0, tx_enable[0]});
    powered <= 4'hf;
    cyc(5);
    chk("dsr no effect", 8'h00, {7'h0, tx_enable[0]});
    ready <= 4'hf;
    cyc(5);
    chk("tx resumed", 8'h01, {7'h0, tx_enable[0]});
    rd(5'h02);
    chk("cts status", 8'h01, {7'h0, d[4]});
    chk("status levels", 8'h0b, {4'h0, d[7:4]});
    wr(5'h01, 8'h00);
  endtask
  task t_ring;
    wr(5'h04, 8'h04);
    rd(5'h04);
    chk("mask readback", 8'h04, d);
    @(posedge core_clk);
    ringing <= 4'h1;
    cyc(6);
    chk("irq on ring start", 8'h00, {7'h0, irq});
    @(posedge core_clk);
    ringing <= 4'h0;
    repeat (5) @(posedge core_clk);
    #1;
    chk("irq on ring end", 8'h01, {7'h0, irq});
    rd(5'h02);
    chk("ring event", 8'h01, {7'h0, d[2]});
    cyc(2);
    chk("irq cleared", 8'h00, {7'h0, irq});
    wr(5'h04, 8'h00);
    @(posedge core_clk);
    ringing <= 4'h1;
    cyc(6);
    ringing <= 4'h0;
    cyc(8);
    chk("irq masked", 8'h00, {7'h0, irq});
    rd(5'h02);
    chk("masked event", 8'h01, {7'h0, d[2]});
  endtask
  task t_reset;
    wr(5'h00, 8'h03);
    cyc(2);
    chk("dtr before reset", 8'h0e, {4'h0, dtr_n});
    chk("rts before reset", 8'h0e, {4'h0, rts_n});
    sys_rst <= 1'h1;
    cyc(2);
    chk("dtr in reset", 8'h0f, {4'h0, dtr_n});
    chk("rts in reset", 8'h0f, {4'h0, rts_n});
    sys_rst <= 1'h0;
    cyc(2);
    chk("dtr after second reset", 8'h0f, {4'h0, dtr_n});
    chk("rts after second reset", 8'h0f, {4'h0, rts_n});
    rd(5'h00);
    chk("control cleared", 8'h00, d);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'h0;
    cyc(1);
    chk("dtr after reset", 8'h0f, {4'h0, dtr_n});
    chk("rts after reset", 8'h0f, {4'h0, rts_n});
    t_space;
    t_mcr;
    t_cts;
    t_ring;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire
